// File: rtl/cmc_consts.svh
// offsets, field positions, reset values and counts of the config block
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH
`define CMC_OFF_MCFG 8'h00
`define CMC_OFF_IRQ_STAT 8'h04
`define CMC_OFF_IRQ_CLR 8'h08
`define CMC_OFF_IRQ_EN 8'h0c
`define CMC_BIT_MODULE_DISABLE 31
`define CMC_BIT_FRZ 30
`define CMC_BIT_HALT 28
`define CMC_BIT_NOTRDY 27
`define CMC_BIT_SRST 25
`define CMC_BIT_FACK 24
`define CMC_BIT_SUPERVISOR_ONLY 23
`define CMC_BIT_DACK 20
`define CMC_LBI_MSB 5
`define CMC_LBI_LSB 0
`define CMC_RST_MODULE_DISABLE 1'b0
`define CMC_RST_FRZ 1'b1
`define CMC_RST_HALT 1'b1
`define CMC_RST_SUPERVISOR_ONLY 1'b1
`define CMC_RST_LBI 6'h1f
`define CMC_IRQ_W 4
`define CMC_IRQ_SRST_DONE 0
`define CMC_IRQ_FRZ_IN 1
`define CMC_IRQ_DIS_IN 2
`define CMC_IRQ_REFUSED 3
`define CMC_SRST_SYNC_CYCLES 2
`define CMC_SRST_HOLD_CYCLES 4
`endif

// File: rtl/cmc_pkg.sv
// types shared by the config block
package cmc_pkg;
    typedef enum logic [1:0] {
        SR_IDLE,
        SR_FWD,
        SR_HOLD,
        SR_BACK
    } cmc_srst_state_e;
endpackage : cmc_pkg

// File: rtl/cmc_srst_handshake.sv
// soft reset request/acknowledge sequencer
`timescale 1ns/1ps
`include "cmc_consts.svh"
module cmc_srst_handshake #(
    parameter int SYNC_CYCLES = `CMC_SRST_SYNC_CYCLES,
    parameter int HOLD_CYCLES = `CMC_SRST_HOLD_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_start,
    output logic o_engine_reset,
    output logic o_done
);
    cmc_pkg::cmc_srst_state_e state_reg;
    logic [7:0] cnt_reg;
    logic done_reg;

    // request travels out, reset is held, acknowledge travels back
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg <= cmc_pkg::SR_IDLE;
            cnt_reg <= 8'h00;
            done_reg <= 1'b0;
        end else if (i_ce) begin
            done_reg <= 1'b0;
            case (state_reg)
                cmc_pkg::SR_IDLE: begin
                    if (i_start) begin
                        state_reg <= cmc_pkg::SR_FWD;
                        cnt_reg <= 8'(SYNC_CYCLES - 1);
                    end
                end
                cmc_pkg::SR_FWD: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= cmc_pkg::SR_HOLD;
                        cnt_reg <= 8'(HOLD_CYCLES - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                cmc_pkg::SR_HOLD: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= cmc_pkg::SR_BACK;
                        cnt_reg <= 8'(SYNC_CYCLES - 1);
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                cmc_pkg::SR_BACK: begin
                    if (cnt_reg == 8'h00) begin
                        state_reg <= cmc_pkg::SR_IDLE;
                        done_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= cmc_pkg::SR_IDLE;
                end
            endcase
        end
    end

    assign o_engine_reset = (state_reg == cmc_pkg::SR_HOLD);
    assign o_done = done_reg;
endmodule : cmc_srst_handshake

// File: rtl/cmc_module_config_control.sv
// module configuration, freeze, disable and soft reset control
// What this block does
// - writing one to soft reset resets sequencer, error counters, flags, timer
// - soft reset restores configuration fields except module disable, and engine registers
// - soft reset leaves bus control, receive masks and buffers alone
// - soft reset bit reads one while pending, hardware clears it when done
// - freeze acknowledge sets once freeze mode is really entered
// - freeze acknowledge clears after prescaler is running again, or together with its restart on soft reset completion
// - supervisor-only bit restricts register access to supervisor mode
// - disable acknowledge reads one only while in disabled mode
// - disabled mode waits until current transfers have finished
// - last buffer index limits matching to buffers zero through index
// - last buffer index resets to 0x1f, all 32 buffers
// - module disable stops interface clocks; soft reset keeps it
// - freeze enable with halt or breakpoint enters freeze; halt set at reset
`timescale 1ns/1ps
`include "cmc_consts.svh"
module cmc_module_config_control #(
    parameter int SRST_SYNC_CYCLES = `CMC_SRST_SYNC_CYCLES,
    parameter int SRST_HOLD_CYCLES = `CMC_SRST_HOLD_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_supervisor,
    input wire logic i_debug_breakpoint,
    input wire logic i_bus_busy,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_soft_reset,
    output logic o_module_disable,
    output logic o_clocks_stopped,
    output logic o_prescaler_enable,
    output logic o_freeze_mode,
    output logic [5:0] o_last_buffer_index
);
    function automatic logic cmc_hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction : cmc_hit

    logic debug_breakpoint_meta_reg;
    logic debug_breakpoint_sync_reg;
    logic module_disable_reg;
    logic frz_en_reg;
    logic halt_reg;
    logic supervisor_only_reg;
    logic [5:0] lbi_reg;
    logic srst_req_reg;
    logic srst_out_reg;
    logic presc_en_reg;
    logic frz_ack_reg;
    logic dis_ack_reg;
    logic [`CMC_IRQ_W-1:0] irq_stat_reg;
    logic [`CMC_IRQ_W-1:0] irq_en_reg;
    logic irq_reg;
    logic [31:0] rdata_reg;
    logic access_ok;
    logic mcfg_wr;
    logic srst_start;
    logic srst_done;
    logic hs_engine_reset;
    logic frz_req;
    logic [`CMC_IRQ_W-1:0] irq_ev;
    logic [`CMC_IRQ_W-1:0] irq_clr;

    // breakpoint is a pin, so it is synchronised before use
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            debug_breakpoint_meta_reg <= 1'b0;
            debug_breakpoint_sync_reg <= 1'b0;
        end else if (i_ce) begin
            debug_breakpoint_meta_reg <= i_debug_breakpoint;
            debug_breakpoint_sync_reg <= debug_breakpoint_meta_reg;
        end
    end

    assign access_ok = !supervisor_only_reg || i_supervisor;
    assign mcfg_wr = i_wr && access_ok && cmc_hit(i_addr, `CMC_OFF_MCFG);
    // a write while a reset is pending does not restart it
    assign srst_start = mcfg_wr && i_wdata[`CMC_BIT_SRST] && !srst_req_reg;
    assign frz_req = frz_en_reg && (halt_reg || debug_breakpoint_sync_reg);

    cmc_srst_handshake #(
        .SYNC_CYCLES(SRST_SYNC_CYCLES),
        .HOLD_CYCLES(SRST_HOLD_CYCLES)
    ) u_srst (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_start(srst_start),
        .o_engine_reset(hs_engine_reset),
        .o_done(srst_done)
    );

    // module disable survives soft reset
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            module_disable_reg <= `CMC_RST_MODULE_DISABLE;
        end else if (i_ce && mcfg_wr) begin
            module_disable_reg <= i_wdata[`CMC_BIT_MODULE_DISABLE];
        end
    end

    // configuration fields; completion of soft reset restores them
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            frz_en_reg <= `CMC_RST_FRZ;
            halt_reg <= `CMC_RST_HALT;
            supervisor_only_reg <= `CMC_RST_SUPERVISOR_ONLY;
            lbi_reg <= `CMC_RST_LBI;
        end else if (i_ce) begin
            if (srst_done) begin
                frz_en_reg <= `CMC_RST_FRZ;
                halt_reg <= `CMC_RST_HALT;
                supervisor_only_reg <= `CMC_RST_SUPERVISOR_ONLY;
                lbi_reg <= `CMC_RST_LBI;
            end else if (mcfg_wr) begin
                frz_en_reg <= i_wdata[`CMC_BIT_FRZ];
                halt_reg <= i_wdata[`CMC_BIT_HALT];
                supervisor_only_reg <= i_wdata[`CMC_BIT_SUPERVISOR_ONLY];
                lbi_reg <= i_wdata[`CMC_LBI_MSB:`CMC_LBI_LSB];
            end
        end
    end

    // pending flag; engine reset pulse is re-timed for a clean output
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            srst_req_reg <= 1'b0;
            srst_out_reg <= 1'b0;
        end else if (i_ce) begin
            srst_out_reg <= hs_engine_reset;
            if (srst_start) begin
                srst_req_reg <= 1'b1;
            end else if (srst_done) begin
                srst_req_reg <= 1'b0;
            end
        end
    end

    // freeze: prescaler stops first, acknowledge follows; on exit the
    // prescaler restarts first; only soft reset completion drops the acknowledge in the same cycle as the restart
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            presc_en_reg <= 1'b1;
            frz_ack_reg <= 1'b0;
        end else if (i_ce) begin
            if (srst_done) begin
                presc_en_reg <= 1'b1;
                frz_ack_reg <= 1'b0;
            end else begin
                if (frz_req && !i_bus_busy) begin
                    presc_en_reg <= 1'b0;
                end else if (!frz_req) begin
                    presc_en_reg <= 1'b1;
                end
                if (frz_req && !presc_en_reg) begin
                    frz_ack_reg <= 1'b1;
                end else if (!frz_req && presc_en_reg) begin
                    frz_ack_reg <= 1'b0;
                end
            end
        end
    end

    // disabled mode is entered only between transfers
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dis_ack_reg <= 1'b0;
        end else if (i_ce) begin
            if (!module_disable_reg) begin
                dis_ack_reg <= 1'b0;
            end else if (!i_bus_busy) begin
                dis_ack_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        irq_ev = '0;
        irq_ev[`CMC_IRQ_SRST_DONE] = srst_done;
        irq_ev[`CMC_IRQ_FRZ_IN] = frz_req && !presc_en_reg && !frz_ack_reg;
        irq_ev[`CMC_IRQ_DIS_IN] = module_disable_reg && !i_bus_busy && !dis_ack_reg;
        irq_ev[`CMC_IRQ_REFUSED] = (i_wr || i_rd) && !access_ok;
        irq_clr = '0;
        if (i_wr && access_ok && cmc_hit(i_addr, `CMC_OFF_IRQ_CLR)) begin
            irq_clr = i_wdata[`CMC_IRQ_W-1:0];
        end
    end

    // a new event outweighs a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_stat_reg <= '0;
        end else if (i_ce) begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_en_reg <= '0;
        end else if (i_ce && i_wr && access_ok && cmc_hit(i_addr, `CMC_OFF_IRQ_EN)) begin
            irq_en_reg <= i_wdata[`CMC_IRQ_W-1:0];
        end
    end

    // one cycle behind the status bit, in exchange for a glitch-free pin
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            irq_reg <= 1'b0;
        end else if (i_ce) begin
            irq_reg <= |(irq_stat_reg & irq_en_reg);
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            rdata_reg <= 32'h0000_0000;
            if (i_rd && access_ok) begin
                case (i_addr)
                    `CMC_OFF_MCFG: begin
                        rdata_reg[`CMC_BIT_MODULE_DISABLE] <= module_disable_reg;
                        rdata_reg[`CMC_BIT_FRZ] <= frz_en_reg;
                        rdata_reg[`CMC_BIT_HALT] <= halt_reg;
                        rdata_reg[`CMC_BIT_NOTRDY] <= frz_ack_reg || dis_ack_reg;
                        rdata_reg[`CMC_BIT_SRST] <= srst_req_reg;
                        rdata_reg[`CMC_BIT_FACK] <= frz_ack_reg;
                        rdata_reg[`CMC_BIT_SUPERVISOR_ONLY] <= supervisor_only_reg;
                        rdata_reg[`CMC_BIT_DACK] <= dis_ack_reg;
                        rdata_reg[`CMC_LBI_MSB:`CMC_LBI_LSB] <= lbi_reg;
                    end
                    `CMC_OFF_IRQ_STAT: begin
                        rdata_reg[`CMC_IRQ_W-1:0] <= irq_stat_reg;
                    end
                    `CMC_OFF_IRQ_EN: begin
                        rdata_reg[`CMC_IRQ_W-1:0] <= irq_en_reg;
                    end
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign o_rdata = rdata_reg;
    assign o_irq = irq_reg;
    // engine reset only; bus setup, masks and buffers never see it
    assign o_soft_reset = srst_out_reg;
    assign o_module_disable = module_disable_reg;
    assign o_clocks_stopped = dis_ack_reg;
    assign o_prescaler_enable = presc_en_reg;
    assign o_freeze_mode = frz_ack_reg;
    assign o_last_buffer_index = lbi_reg;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst || !i_ce);

    sequence s_frz_entry;
        (frz_req && !i_bus_busy && presc_en_reg) ##1 (frz_req && !srst_done);
    endsequence

    sequence s_srst_write;
        srst_start;
    endsequence

    AST_SRST_SETS: assert property (s_srst_write |=> srst_req_reg)
        else $error("soft reset request did not read as pending");

    AST_SRST_CLEARS: assert property (srst_done |=> !srst_req_reg)
        else $error("soft reset request not cleared on completion");

    AST_SRST_ENGINE: assert property (s_srst_write |-> ##[1:20] o_soft_reset)
        else $error("engine reset not issued after soft reset request");

    AST_SRST_FIELDS: assert property (srst_done |=>
        (lbi_reg == `CMC_RST_LBI) && (halt_reg == `CMC_RST_HALT)
        && (frz_en_reg == `CMC_RST_FRZ) && (supervisor_only_reg == `CMC_RST_SUPERVISOR_ONLY))
        else $error("configuration fields not restored by soft reset");

    AST_SRST_KEEPS_MODULE_DISABLE: assert property ((srst_done && !mcfg_wr) |=> $stable(module_disable_reg))
        else $error("module disable changed by soft reset");

    AST_FRZ_ACK: assert property (s_frz_entry |=> frz_ack_reg)
        else $error("freeze acknowledge late after freeze entry");

    AST_FRZ_EXIT: assert property ($fell(frz_ack_reg) |-> $past(presc_en_reg))
        else $error("freeze acknowledge cleared before prescaler restart");

    AST_FRZ_REQ: assert property ((frz_req && !i_bus_busy && !srst_done)[*3]
        |-> frz_ack_reg)
        else $error("freeze not entered on halt or breakpoint");

    AST_SUPERVISOR_ONLY_BLOCK: assert property ((supervisor_only_reg && !i_supervisor && i_wr
        && cmc_hit(i_addr, `CMC_OFF_IRQ_EN)) |=> $stable(irq_en_reg))
        else $error("user write changed a protected register");

    AST_DIS_WAIT: assert property ($rose(dis_ack_reg) |-> $past(module_disable_reg && !i_bus_busy))
        else $error("disabled mode entered during a transfer");

    AST_DIS_CLR: assert property (!module_disable_reg |=> !dis_ack_reg)
        else $error("disable acknowledge set while enabled");

    AST_LBI_WRITE: assert property ((mcfg_wr && !srst_done) |=>
        (o_last_buffer_index == $past(i_wdata[`CMC_LBI_MSB:`CMC_LBI_LSB])))
        else $error("last buffer index not taken from write");

    sequence s_frz_release;
        (!frz_req && frz_ack_reg && !presc_en_reg) ##1 (!frz_req && !srst_done);
    endsequence

    AST_FRZ_RELEASE: assert property (s_frz_release |=> !frz_ack_reg)
        else $error("freeze acknowledge held after prescaler restart");

    AST_PRESC_STOP: assert property ((frz_req && !i_bus_busy && !srst_done)
        |=> !presc_en_reg)
        else $error("prescaler still running after freeze request");

    AST_DIS_ENTRY: assert property ((module_disable_reg && !i_bus_busy) |=> dis_ack_reg)
        else $error("disabled mode not entered with the bus idle");

    AST_STAT_STICKY: assert property ((irq_ev != '0)
        |=> ((irq_stat_reg & $past(irq_ev)) == $past(irq_ev)))
        else $error("status bit not set by its event");

    AST_IRQ_HIGH: assert property ((|(irq_stat_reg & irq_en_reg)) |=> o_irq)
        else $error("interrupt low with an enabled status bit");

    AST_IRQ_LOW: assert property ((!(|(irq_stat_reg & irq_en_reg))) |=> !o_irq)
        else $error("interrupt high with no enabled status bit");

    AST_RDATA_IDLE: assert property (!i_rd |=> (o_rdata == 32'h0000_0000))
        else $error("read data not zero outside a read");

    AST_REFUSED_READ: assert property ((i_rd && !access_ok) |=> (o_rdata == 32'h0000_0000))
        else $error("refused read returned data");

    AST_CE_FREEZE: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !i_ce |=> ($stable(frz_ack_reg) && $stable(lbi_reg) && $stable(irq_stat_reg)
        && $stable(o_rdata)))
        else $error("state moved while the clock enable was low");
endmodule : cmc_module_config_control

// File: verification/cmc_module_config_control_test.sv
// self-checking bench for the module configuration block
`timescale 1ns/1ps
`include "cmc_consts.svh"
module cmc_module_config_control_test;
    logic i_clk = 0, i_nrst = 0, i_ce = 1, i_wr = 0, i_rd = 0, i_supervisor = 0;
    logic i_debug_breakpoint = 0, i_bus_busy = 0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd_val;
    logic o_irq, o_soft_reset, o_module_disable, o_clocks_stopped, o_prescaler_enable;
    logic o_freeze_mode, prev_frz = 0, prev_pre = 0, seen_srst = 0;
    logic [5:0] o_last_buffer_index;
    int num_errors = 0, n_tests = 0, cycles = 0, seed = 4, i;
    // bench model of the writable configuration fields
    int m_module_disable = 0, m_frz = 1, m_halt = 1, m_supervisor_only = 1, m_lbi = 31;

    cmc_module_config_control #(.SRST_SYNC_CYCLES(2), .SRST_HOLD_CYCLES(4))
        cmc_module_config_control_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_supervisor(i_supervisor), .i_debug_breakpoint(i_debug_breakpoint),
        .i_bus_busy(i_bus_busy), .o_rdata(o_rdata), .o_irq(o_irq),
        .o_soft_reset(o_soft_reset), .o_module_disable(o_module_disable),
        .o_clocks_stopped(o_clocks_stopped), .o_prescaler_enable(o_prescaler_enable),
        .o_freeze_mode(o_freeze_mode), .o_last_buffer_index(o_last_buffer_index));

    always #50 i_clk = ~i_clk;

    function automatic logic [31:0] mcfg(int fack, int dack, int srst);
        mcfg = 32'((m_module_disable << 31) | (m_frz << 30) | (m_halt << 28) | ((fack | dack) << 27)
            | (srst << 25) | (fack << 24) | (m_supervisor_only << 23) | (dack << 20) | m_lbi);
    endfunction : mcfg

    function automatic logic flag(int w);
        case (w)
            0: flag = o_freeze_mode;
            1: flag = o_clocks_stopped;
            default: flag = o_irq;
        endcase
    endfunction : flag

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(logic [7:0] a, logic [31:0] d, logic s);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        i_supervisor <= s;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr

    // read data are taken in the one cycle they stand
    task automatic rd(logic [7:0] a, logic s);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        i_supervisor <= s;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
    endtask : rd

    task automatic wrm();
        wr(`CMC_OFF_MCFG, mcfg(0, 0, 0), 1'b1);
    endtask : wrm

    // bounded wait; the caller's compare catches a timeout
    task automatic wait_on(int w, logic v);
        for (int k = 0; k < 20; k++) begin
            @(posedge i_clk);
            #1;
            if (flag(w) === v) break;
        end
    endtask : wait_on

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            num_errors++;
            report_and_stop();
        end
        if (o_soft_reset === 1'b1) seen_srst <= 1'b1;
        if (prev_frz === 1'b1 && o_freeze_mode === 1'b0) begin
            chk(32'(prev_pre), 32'h1, "prescaler before ack drop");
        end
        prev_frz <= o_freeze_mode;
        prev_pre <= o_prescaler_enable;
    end

    initial begin
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        wait_on(0, 1'b1);
        chk(32'({o_freeze_mode, o_prescaler_enable}), 32'h2, "freeze after reset");
        chk(32'(o_last_buffer_index), 32'h1f, "index reset");
        rd(`CMC_OFF_MCFG, 1'b1);
        chk(rd_val, mcfg(1, 0, 0), "mcfg reset");
        rd(`CMC_OFF_IRQ_STAT, 1'b1);
        chk(rd_val & 32'h2, 32'h2, "freeze event");
        $display("done: reset values");
        for (i = 0; i < 5; i++) begin
            m_lbi = (i == 0) ? 0 : (i == 4) ? 42 : ($random(seed) & 63);
            wrm();
            rd(`CMC_OFF_MCFG, 1'b1);
            chk(rd_val, mcfg(1, 0, 0), "index readback");
            chk(32'(o_last_buffer_index), 32'(m_lbi), "index port");
        end
        $display("done: buffer index");
        m_halt = 0;
        wrm();
        wait_on(0, 1'b0);
        chk(32'({o_freeze_mode, o_prescaler_enable}), 32'h1, "freeze exit");
        rd(`CMC_OFF_MCFG, 1'b1);
        chk(rd_val, mcfg(0, 0, 0), "ack cleared");
        @(posedge i_clk) i_debug_breakpoint <= 1'b1;
        wait_on(0, 1'b1);
        chk(32'(o_freeze_mode), 32'h1, "breakpoint freeze");
        @(posedge i_clk) i_debug_breakpoint <= 1'b0;
        wait_on(0, 1'b0);
        chk(32'(o_freeze_mode), 32'h0, "breakpoint release");
        m_frz = 0;
        wrm();
        @(posedge i_clk) i_debug_breakpoint <= 1'b1;
        repeat (8) @(posedge i_clk);
        #1 chk(32'(o_freeze_mode), 32'h0, "freeze disabled");
        @(posedge i_clk) i_debug_breakpoint <= 1'b0;
        m_frz = 1;
        wrm();
        @(posedge i_clk) i_bus_busy <= 1'b1;
        m_halt = 1;
        wrm();
        repeat (8) @(posedge i_clk);
        #1 chk(32'(o_freeze_mode), 32'h0, "freeze waits for bus");
        @(posedge i_clk) i_bus_busy <= 1'b0;
        wait_on(0, 1'b1);
        chk(32'(o_freeze_mode), 32'h1, "freeze after bus idle");
        m_halt = 0;
        wrm();
        wait_on(0, 1'b0);
        $display("done: freeze");
        @(posedge i_clk) i_bus_busy <= 1'b1;
        m_module_disable = 1;
        wrm();
        repeat (8) @(posedge i_clk);
        #1 chk(32'(o_clocks_stopped), 32'h0, "disable waits for transfer");
        rd(`CMC_OFF_MCFG, 1'b1);
        chk(rd_val, mcfg(0, 0, 0), "no ack while busy");
        @(posedge i_clk) i_bus_busy <= 1'b0;
        wait_on(1, 1'b1);
        chk(32'({o_clocks_stopped, o_module_disable}), 32'h3, "disabled");
        rd(`CMC_OFF_MCFG, 1'b1);
        chk(rd_val, mcfg(0, 1, 0), "disable ack");
        m_module_disable = 0;
        wrm();
        wait_on(1, 1'b0);
        chk(32'(o_clocks_stopped), 32'h0, "enabled again");
        $display("done: disable");
        wr(`CMC_OFF_IRQ_CLR, 32'hf, 1'b1);
        wr(`CMC_OFF_IRQ_EN, 32'h8, 1'b1);
        wr(`CMC_OFF_MCFG, 32'h3, 1'b0);
        wr(`CMC_OFF_IRQ_EN, 32'h0, 1'b0);
        rd(`CMC_OFF_IRQ_EN, 1'b1);
        chk(rd_val, 32'h8, "user enable write refused");
        rd(`CMC_OFF_MCFG, 1'b0);
        chk(rd_val, 32'h0, "user read refused");
        rd(`CMC_OFF_MCFG, 1'b1);
        chk(rd_val, mcfg(0, 0, 0), "user write refused");
        rd(`CMC_OFF_IRQ_STAT, 1'b1);
        chk(rd_val, 32'h8, "refusal event");
        chk(32'(o_irq), 32'h1, "irq raised");
        wr(`CMC_OFF_IRQ_EN, 32'h0, 1'b1);
        repeat (2) @(posedge i_clk);
        #1 chk(32'(o_irq), 32'h0, "irq masked");
        wr(`CMC_OFF_IRQ_EN, 32'h8, 1'b1);
        wait_on(2, 1'b1);
        wr(`CMC_OFF_IRQ_CLR, 32'h8, 1'b1);
        wait_on(2, 1'b0);
        chk(32'(o_irq), 32'h0, "irq cleared");
        @(posedge i_clk) i_ce <= 1'b0;
        wr(`CMC_OFF_IRQ_EN, 32'h4, 1'b1);
        i_ce <= 1'b1;
        rd(`CMC_OFF_IRQ_EN, 1'b1);
        chk(rd_val, 32'h8, "write ignored with clock enable low");
        wr(`CMC_OFF_IRQ_STAT, 32'hf, 1'b1);
        rd(`CMC_OFF_IRQ_STAT, 1'b1);
        chk(rd_val, 32'h0, "status read only");
        rd(8'h10, 1'b1);
        chk(rd_val, 32'h0, "unmapped read");
        m_supervisor_only = 0;
        wrm();
        m_frz = 0;
        wr(`CMC_OFF_MCFG, mcfg(0, 0, 0), 1'b0);
        rd(`CMC_OFF_MCFG, 1'b0);
        chk(rd_val, mcfg(0, 0, 0), "user access open");
        $display("done: access and interrupt");
        m_module_disable = 1;
        wr(`CMC_OFF_MCFG, mcfg(0, 0, 1), 1'b1);
        rd(`CMC_OFF_MCFG, 1'b1);
        chk(rd_val & 32'h2000000, 32'h2000000, "reset pending");
        for (i = 0; i < 20 && rd_val[`CMC_BIT_SRST] !== 1'b0; i++) rd(`CMC_OFF_MCFG, 1'b1);
        chk(32'(seen_srst), 32'h1, "engine reset pulse");
        m_frz = 1;
        m_halt = 1;
        m_supervisor_only = 1;
        m_lbi = 31;
        chk(rd_val & 32'hf6efffff, mcfg(0, 0, 0), "fields after soft reset");
        chk(32'({o_module_disable, o_last_buffer_index}), 32'h5f, "ports after reset");
        rd(`CMC_OFF_IRQ_STAT, 1'b1);
        chk(rd_val & 32'h1, 32'h1, "reset done event");
        m_module_disable = 0;
        wrm();
        $display("done: soft reset");
        report_and_stop();
    end
endmodule : cmc_module_config_control_test
